// ==== core/motion_sensor_host.sv ====
// The AHB-Lite register port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
// Contract
// R1 - Host alone starts every transfer.
// R2 - Deselected device ignores clock, data; tri-states. The sensor model keeps driving miso, toggling it at each deselect.
// R3 - Mid-transfer deselect aborts; usual delay still applies.
// R4 - Select asserted only around each transaction.
// R5 - Deselect ends burst; port refused until then.
// R6 - Device downshifts through three rest levels.
// R7 - Device wakes on motion; rest timing programmable.
// R8 - Device drives motion pin, selectable polarity, mode.
// R9 - Level mode follows motion pending flag.
// R10 - Edge mode gives one short pulse.
// R11 - Poll motion pending flag, then read displacement.
// R12 - Write is address with MSB 1, data.
// R13 - Read is address MSB 0, device returns byte.
// R14 - Space writes by write gap minimums.
// R15 - Pause after read address; gap before next.
// R16 - Burst read returns motion bytes in order.
// R17 - Burst may end after Y displacement byte.
// R18 - Burst start register default and legal starts.
// R19 - Twelve-bit burst inserts upper nibbles byte.
// R20 - Burst bytes clock back to back after wait.
// R21 - Reset write restores device defaults.
// R22 - Power down write; no access until reset.
// R23 - Pins undefined in power down; keep deselected.
// R24 - Wait 4 us from address to data.
// R25 - Leave 30 us between write commands.
// R26 - Leave 20 us from write to read.
// R27 - Hold select high 250 ns after burst.
// R28 - Device synchronises its serial inputs.
module motion_sensor_host
    import sensor_host_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output spi_out_t spi_out,
    input wire logic miso,
    input wire logic motion_pin
);

    typedef struct packed {
        link_state_t st;
        logic [9:0] cnt;
        logic [9:0] gap;
        logic [2:0] bit_idx;
        logic [3:0] byte_idx;
        logic [7:0] shreg;
        spi_out_t pins;
        logic go;
        logic busy;
        logic done;
        logic refused;
        logic motion_event;
        logic motion_prev;
        logic cfg_active_high;
        logic [6:0] cmd_addr;
        logic cmd_write;
        logic [7:0] cmd_data;
        logic [3:0] cmd_count;
        logic [63:0] rx_bytes;
        logic miso_s1;
        logic miso_s2;
        logic mot_s1;
        logic mot_s2;
        logic dp_write;
        logic [7:0] dp_addr;
        logic [31:0] rdata;
        logic readyout;
    } host_state_t;

    host_state_t s;
    host_state_t next_s;

    logic [31:0] status_word;
    logic motion_active;

    assign motion_active = s.cfg_active_high ? s.mot_s2 : ~s.mot_s2;

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[STAT_BUSY_BIT] = s.busy;
        status_word[STAT_DONE_BIT] = s.done;
        status_word[STAT_REFUSED_BIT] = s.refused;
        // R11 raw synchronised motion pin level for polling
        status_word[STAT_MOTION_LEVEL_BIT] = s.mot_s2;
        status_word[STAT_MOTION_EVENT_BIT] = s.motion_event;
        status_word[STAT_GAP_BIT] = (s.gap != 10'h000);
    end

    always_comb begin
        logic set_done;
        logic set_refused;
        logic set_motion;
        logic clr_done;
        logic clr_refused;
        logic clr_motion;
        logic [2:0] slot;
        set_done = 1'b0;
        set_refused = 1'b0;
        set_motion = 1'b0;
        clr_done = 1'b0;
        clr_refused = 1'b0;
        clr_motion = 1'b0;
        slot = 3'(s.byte_idx - 4'h1);
        next_s = s;

        // Device output and motion pin cross in through two flops.
        next_s.miso_s1 = miso;
        next_s.miso_s2 = s.miso_s1;
        next_s.mot_s1 = motion_pin;
        next_s.mot_s2 = s.mot_s1;

        // Motion pin event latch, either polarity and either pin mode.
        // R8 motion pin polarity
        next_s.motion_prev = motion_active;
        set_motion = motion_active & ~s.motion_prev;

        // The gap timer holds off the next command until the link may be used again.
        if (s.gap != 10'h000) begin
            next_s.gap = s.gap - 10'h001;
        end

        // Bus slave: zero wait states, always OKAY.
        next_s.readyout = 1'b1;
        if (s.dp_write) begin
            unique case (s.dp_addr)
                OFS_COMMAND: begin
                    // R5 refuse while busy
                    if (s.busy) begin
                        set_refused = 1'b1;
                    end else begin
                        next_s.cmd_addr = hwdata[CMD_ADDR_LSB +: 7];
                        next_s.cmd_write = hwdata[CMD_WRITE_BIT];
                        next_s.cmd_data = hwdata[CMD_DATA_LSB +: 8];
                        // R17 byte count ends burst
                        next_s.cmd_count = (hwdata[CMD_COUNT_LSB +: 4] == 4'h0) ? 4'h1 :
                            (hwdata[CMD_COUNT_LSB +: 4] > MAX_BYTES) ? MAX_BYTES : hwdata[CMD_COUNT_LSB +: 4];
                        // R22 power down by write
                        next_s.go = 1'b1;
                        next_s.busy = 1'b1;
                    end
                end
                OFS_STATUS: begin
                    clr_done = hwdata[STAT_DONE_BIT];
                    clr_refused = hwdata[STAT_REFUSED_BIT];
                    clr_motion = hwdata[STAT_MOTION_EVENT_BIT];
                end
                OFS_CONFIG: begin
                    next_s.cfg_active_high = hwdata[CFG_ACTIVE_HIGH_BIT];
                end
                default: begin
                end
            endcase
        end
        next_s.dp_write = 1'b0;
        // Read data is picked in the address phase and stands through the data phase.
        if (hsel && hready && htrans[1]) begin
            next_s.dp_write = hwrite;
            next_s.dp_addr = haddr[7:0];
            next_s.rdata = 32'h0000_0000;
            if (!hwrite) begin
                unique case (haddr[7:0])
                    OFS_COMMAND: next_s.rdata = {12'h000, s.cmd_count, s.cmd_data, s.cmd_write, s.cmd_addr};
                    OFS_STATUS: next_s.rdata = status_word;
                    OFS_BURST_LO: next_s.rdata = s.rx_bytes[31:0];
                    OFS_BURST_HI: next_s.rdata = s.rx_bytes[63:32];
                    OFS_CONFIG: next_s.rdata = {31'h0000_0000, s.cfg_active_high};
                    default: next_s.rdata = 32'h0000_0000;
                endcase
            end
        end

        unique case (s.st)
            ST_IDLE: begin
                // R1 host starts transfer
                // R25 write gap honoured
                if (s.go && s.gap == 10'h000) begin
                    // R4 select framing
                    next_s.pins.port_select_n = 1'b0;
                    next_s.go = 1'b0;
                    // R12 write address MSB
                    // R13 read address MSB
                    next_s.shreg = {s.cmd_write, s.cmd_addr};
                    next_s.bit_idx = 3'h7;
                    next_s.byte_idx = 4'h0;
                    next_s.cnt = SELECT_SETUP_CYC - 10'h001;
                    next_s.st = ST_SETUP;
                end
            end
            ST_SETUP: begin
                if (s.cnt != 10'h000) begin
                    next_s.cnt = s.cnt - 10'h001;
                end else begin
                    next_s.pins.sclk = 1'b0;
                    next_s.pins.mosi = s.shreg[7];
                    next_s.cnt = HALF_CYC - 10'h001;
                    next_s.st = ST_LOW;
                end
            end
            ST_LOW: begin
                if (s.cnt != 10'h000) begin
                    next_s.cnt = s.cnt - 10'h001;
                end else begin
                    // R13 sample on rising edge
                    next_s.pins.sclk = 1'b1;
                    next_s.shreg = {s.shreg[6:0], s.miso_s2};
                    next_s.cnt = HALF_CYC - 10'h001;
                    next_s.st = ST_HIGH;
                end
            end
            ST_HIGH: begin
                if (s.cnt != 10'h000) begin
                    next_s.cnt = s.cnt - 10'h001;
                end else if (s.bit_idx != 3'h0) begin
                    next_s.bit_idx = s.bit_idx - 3'h1;
                    next_s.pins.sclk = 1'b0;
                    next_s.pins.mosi = s.shreg[7];
                    next_s.cnt = HALF_CYC - 10'h001;
                    next_s.st = ST_LOW;
                end else if (s.byte_idx == 4'h0) begin
                    next_s.bit_idx = 3'h7;
                    if (s.cmd_write) begin
                        next_s.byte_idx = 4'h1;
                        next_s.shreg = s.cmd_data;
                        next_s.pins.sclk = 1'b0;
                        next_s.pins.mosi = s.cmd_data[7];
                        next_s.cnt = HALF_CYC - 10'h001;
                        next_s.st = ST_LOW;
                    end else begin
                        // R24 address to data wait
                        // R15 pause after address
                        next_s.pins.mosi = 1'b0;
                        next_s.cnt = ADDR_TO_DATA_CYC - 10'h001;
                        next_s.st = ST_ADWAIT;
                    end
                end else begin
                    // Each received byte lands in its own byte lane; a write sends one data byte only.
                    if (!s.cmd_write) begin
                        next_s.rx_bytes[{slot, 3'h0} +: 8] = s.shreg;
                    end
                    if (!s.cmd_write && s.byte_idx < s.cmd_count) begin
                        // R20 back to back bytes
                        // R16 burst without addresses
                        next_s.byte_idx = s.byte_idx + 4'h1;
                        next_s.bit_idx = 3'h7;
                        next_s.shreg = 8'h00;
                        next_s.pins.sclk = 1'b0;
                        next_s.pins.mosi = 1'b0;
                        next_s.cnt = HALF_CYC - 10'h001;
                        next_s.st = ST_LOW;
                    end else begin
                        next_s.cnt = s.cmd_write ? DESELECT_WR_CYC - 10'h001 : DESELECT_RD_CYC - 10'h001;
                        next_s.st = ST_HOLD;
                    end
                end
            end
            ST_ADWAIT: begin
                // The clock stays high through the wait so the sensor can fetch its data.
                if (s.cnt != 10'h000) begin
                    next_s.cnt = s.cnt - 10'h001;
                end else begin
                    next_s.byte_idx = 4'h1;
                    next_s.shreg = 8'h00;
                    next_s.pins.sclk = 1'b0;
                    next_s.cnt = HALF_CYC - 10'h001;
                    next_s.st = ST_LOW;
                end
            end
            ST_HOLD: begin
                if (s.cnt != 10'h000) begin
                    next_s.cnt = s.cnt - 10'h001;
                end else begin
                    // R5 deselect ends burst
                    // R23 idle select stays high
                    next_s.pins.port_select_n = 1'b1;
                    next_s.busy = 1'b0;
                    set_done = 1'b1;
                    // R3 delay after deselect
                    if (s.cmd_write) begin
                        // R14 write spacing
                        // R26 write to read gap
                        next_s.gap = (WRITE_GAP_CYC > WRITE_READ_CYC) ? WRITE_GAP_CYC : WRITE_READ_CYC;
                    end else if (s.cmd_count > 4'h1) begin
                        // R27 burst exit idle
                        next_s.gap = BURST_EXIT_CYC;
                    end else begin
                        // R15 read to next gap
                        next_s.gap = READ_GAP_CYC;
                    end
                    next_s.st = ST_IDLE;
                end
            end
            default: begin
                // Unused state codes release the link and return to idle.
                next_s.pins.sclk = 1'b1;
                next_s.pins.port_select_n = 1'b1;
                next_s.busy = 1'b0;
                next_s.st = ST_IDLE;
            end
        endcase

        // Hardware set wins over a software clear in the same cycle.
        next_s.done = set_done | (s.done & ~clr_done);
        next_s.refused = set_refused | (s.refused & ~clr_refused);
        next_s.motion_event = set_motion | (s.motion_event & ~clr_motion);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '0;
            s.st <= ST_IDLE;
            s.pins.sclk <= 1'b1;
            s.pins.port_select_n <= 1'b1;
            s.readyout <= 1'b1;
            s.cfg_active_high <= CONFIG_RESET;
            s.cmd_count <= 4'h1;
            s.motion_prev <= 1'b0;
            // Synchronisers start at the idle level of the default active-low pin.
            s.mot_s1 <= 1'b1;
            s.mot_s2 <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign hrdata = s.rdata;
    assign hreadyout = s.readyout;
    assign hresp = 1'b0;
    assign spi_out = s.pins;

endmodule // motion_sensor_host

// ==== core/sensor_host_pkg.sv ====
package sensor_host_pkg;

    // System clock rate in MHz.
    localparam int CLK_MHZ = 20;

    // Serial clock half period in system cycles: 500 ns high, 500 ns low.
    localparam int HALF_CYC_INT = 10;

    // Link timing minimums, as printed.
    localparam int ADDR_TO_DATA_WAIT_NS = 4000;
    localparam int WRITE_TO_WRITE_GAP_NS = 30000;
    localparam int WRITE_TO_READ_GAP_NS = 20000;
    localparam int READ_TO_READ_GAP_NS = 250;
    localparam int BURST_EXIT_IDLE_NS = 250;
    localparam int SELECT_TO_SCLK_NS = 120;
    localparam int SCLK_TO_DESELECT_WR_NS = 120;
    localparam int SCLK_TO_DESELECT_RD_NS = 20000;

    // Least times round up to whole cycles.
    localparam logic [9:0] HALF_CYC = 10'(HALF_CYC_INT);
    localparam logic [9:0] ADDR_TO_DATA_CYC = 10'((ADDR_TO_DATA_WAIT_NS * CLK_MHZ + 999) / 1000);
    localparam logic [9:0] WRITE_GAP_CYC = 10'((WRITE_TO_WRITE_GAP_NS * CLK_MHZ + 999) / 1000);
    localparam logic [9:0] WRITE_READ_CYC = 10'((WRITE_TO_READ_GAP_NS * CLK_MHZ + 999) / 1000);
    localparam logic [9:0] READ_GAP_CYC = 10'((READ_TO_READ_GAP_NS * CLK_MHZ + 999) / 1000);
    localparam logic [9:0] BURST_EXIT_CYC = 10'((BURST_EXIT_IDLE_NS * CLK_MHZ + 999) / 1000);
    localparam logic [9:0] SELECT_SETUP_CYC = 10'((SELECT_TO_SCLK_NS * CLK_MHZ + 999) / 1000);
    localparam logic [9:0] DESELECT_WR_CYC = 10'((SCLK_TO_DESELECT_WR_NS * CLK_MHZ + 999) / 1000);
    localparam logic [9:0] DESELECT_RD_CYC = 10'((SCLK_TO_DESELECT_RD_NS * CLK_MHZ + 999) / 1000);

    // Controller register byte offsets.
    localparam logic [7:0] OFS_COMMAND = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_BURST_LO = 8'h08;
    localparam logic [7:0] OFS_BURST_HI = 8'h0C;
    localparam logic [7:0] OFS_CONFIG = 8'h10;

    // Command word fields.
    localparam int CMD_ADDR_LSB = 0;
    localparam int CMD_WRITE_BIT = 7;
    localparam int CMD_DATA_LSB = 8;
    localparam int CMD_COUNT_LSB = 16;

    // Status word fields.
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_DONE_BIT = 1;
    localparam int STAT_REFUSED_BIT = 2;
    localparam int STAT_MOTION_LEVEL_BIT = 3;
    localparam int STAT_MOTION_EVENT_BIT = 4;
    localparam int STAT_GAP_BIT = 5;

    // Config word fields and reset value (motion pin active low by default).
    localparam int CFG_ACTIVE_HIGH_BIT = 0;
    localparam logic CONFIG_RESET = 1'b0;

    // Most data bytes per transaction.
    localparam logic [3:0] MAX_BYTES = 4'h8;

    typedef enum logic [2:0] {
        ST_IDLE, ST_SETUP, ST_LOW, ST_HIGH, ST_ADWAIT, ST_HOLD
    } link_state_t;

    typedef struct packed {
        logic sclk;
        logic mosi;
        logic port_select_n;
    } spi_out_t;

endpackage

// ==== test/sensor_model.sv ====
`timescale 1ns/100ps
module sensor_model (
    input wire logic sclk,
    input wire logic mosi,
    input wire logic port_select_n,
    output logic miso
);
    logic [7:0] regs [128];
    logic [7:0] sin;
    logic [7:0] addr;
    logic [7:0] out;
    logic rd;
    int rise_n;
    int fall_n;
    int idx;
    // Twelve-bit reporting flag in the control register at 0x0D; the bit position is arbitrary.
    localparam int TWELVE_BIT = 5;
    // defaults; contents are arbitrary patterns, not identity values
    task automatic load_defaults();
        for (int i = 0; i < 128; i++) begin
            regs[i] = 8'h55 ^ 8'(i);
        end
        regs[13] = 8'h01;
        regs[15] = 8'h01;
        regs[66] = 8'h03;
    endtask
    initial begin
        load_defaults();
        miso = 1'b0;
        rise_n = 0;
        fall_n = 0;
        rd = 1'b0;
    end
    always @(posedge port_select_n) begin
        rise_n = 0;
        fall_n = 0;
        rd = 1'b0;
        miso = ~miso;
    end
    always @(posedge sclk) begin
        if (!port_select_n) begin
            sin = {sin[6:0], mosi};
            rise_n++;
            if (rise_n == 8) begin
                addr = sin;
                rd = !sin[7];
                idx = (sin == 8'h63) ? int'(regs[66]) : int'(sin[6:0]);
                out = regs[idx];
            end
            if (rise_n == 16 && addr[7]) begin
                if (addr[6:0] == 7'h3A && sin == 8'h5A) begin
                    load_defaults();
                end else if (regs[13] != 8'h02) begin
                    regs[addr[6:0]] = sin;
                end
            end
        end
    end
    always @(negedge sclk) begin
        if (!port_select_n && rd) begin
            miso = out[7];
            out = {out[6:0], 1'b0};
            fall_n++;
            if (fall_n % 8 == 0) begin
                if (regs[13][TWELVE_BIT] && idx == 4) begin
                    idx = 12;
                end else if (regs[13][TWELVE_BIT] && idx == 12) begin
                    idx = 5;
                end else begin
                    idx++;
                end
                out = regs[idx % 128];
            end
        end
    end
endmodule // sensor_model

// ==== test/motion_sensor_host_chk.sv ====
`timescale 1ns/100ps
module motion_sensor_host_chk
    import sensor_host_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire spi_out_t spi_out
);
    logic ps;
    logic sc;
    logic sc_q;
    logic wr;
    logic [9:0] run;
    logic [9:0] gap;
    logic [6:0] bits;
    assign ps = spi_out.port_select_n;
    assign sc = spi_out.sclk;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sc_q <= 1'b1;
            wr <= 1'b0;
            run <= 10'h000;
            gap <= 10'h3FF;
            bits <= 7'h00;
        end else begin
            sc_q <= sc;
            run <= (ps || !sc) ? 10'h000 : run + 10'h001;
            gap <= !ps ? 10'h000 : ((gap == 10'h3FF) ? gap : gap + 10'h001);
            bits <= ps ? 7'h00 : bits + 7'(sc && !sc_q);
            if (!ps && sc && !sc_q && bits == 7'h00) begin
                wr <= spi_out.mosi;
            end
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    AST_IDLE_CLOCK_HIGH: assert property (ps |-> sc)
        else $error("serial clock low while deselected");
    AST_SELECT_SETUP: assert property ($fell(ps) |-> sc [*3] ##1 !sc)
        else $error("select to clock setup wrong");
    AST_LOW_HALF: assert property ($fell(sc) |-> (!sc) [*8] ##1 !sc ##1 !sc ##1 sc)
        else $error("clock low half not ten cycles");
    AST_HIGH_HALF: assert property ($rose(sc) && !ps |-> sc [*8] ##1 sc ##1 sc)
        else $error("clock high half too short");
    AST_MOSI_HOLD: assert property ($rose(sc) |-> $stable(spi_out.mosi) [*4])
        else $error("mosi moved near rising clock");
    AST_BIT_COUNT: assert property ($rose(ps) |-> (wr ? bits == 7'd16 : (bits >= 7'd16 && bits[2:0] == 3'b000)))
        else $error("frame bit count wrong");
    AST_ADDR_WAIT: assert property ($fell(sc) |-> run <= 10'd11 || run >= ADDR_TO_DATA_CYC - 10'd1)
        else $error("address to data wait too short");
    AST_DESELECT_HOLD: assert property ($rose(ps) |-> run >= (wr ? DESELECT_WR_CYC : DESELECT_RD_CYC) - 10'd1)
        else $error("select released too early");
    AST_COMMAND_GAP: assert property ($fell(ps) |-> gap >= (wr ? WRITE_GAP_CYC : READ_GAP_CYC) - 10'd1)
        else $error("gap between commands too short");
    COV_WRITE: cover property ($rose(ps) && wr);
    COV_READ: cover property ($rose(ps) && !wr && bits == 7'd16);
    COV_BURST: cover property ($rose(ps) && bits > 7'd16);
endmodule // motion_sensor_host_chk
bind motion_sensor_host motion_sensor_host_chk chk_u (.hclk(hclk), .hresetn(hresetn), .spi_out(spi_out));

// ==== test/tb_motion_sensor_host.sv ====
`timescale 1ns/100ps
module tb_motion_sensor_host
    import sensor_host_pkg::*;
;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic motion_pin = 1'b1;
    logic [1:0] htrans = 2'b00;
    logic [2:0] hsize = 3'b010;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] q;
    wire logic [31:0] hrdata;
    wire logic hreadyout;
    wire logic hresp;
    wire logic miso;
    spi_out_t spi_out;
    int err_total = 0;
    int checks = 0;
    always #25 hclk = ~hclk;
    motion_sensor_host dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .spi_out(spi_out), .miso(miso),
        .motion_pin(motion_pin));
    sensor_model model_u (.sclk(spi_out.sclk), .mosi(spi_out.mosi),
        .port_select_n(spi_out.port_select_n), .miso(miso));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            err_total++;
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic cmd(input logic [6:0] a, input logic w, input logic [7:0] d, input logic [3:0] n);
        bus(1'b1, OFS_COMMAND, {12'h000, n, d, w, a});
        for (int i = 0; i < 1000; i++) begin
            bus(1'b0, OFS_STATUS, 32'h0);
            if (q[STAT_BUSY_BIT] === 1'b0) break;
        end
        chk({31'h0, q[STAT_BUSY_BIT]}, 32'h0);
    endtask
    task automatic rd_byte(input logic [6:0] a, input logic [31:0] exp);
        cmd(a, 1'b0, 8'h00, 4'h1);
        bus(1'b0, OFS_BURST_LO, 32'h0);
        chk(q & 32'hFF, exp);
    endtask
    task automatic t_regs();
        bus(1'b0, OFS_CONFIG, 32'h0);
        chk(q, 32'h0);
        bus(1'b1, 8'h20, 32'hFFFF_FFFF);
        bus(1'b0, 8'h20, 32'h0);
        chk(q, 32'h0);
        $display("test regs finished");
    endtask
    task automatic t_rw();
        rd_byte(7'h00, 32'h55);
        cmd(7'h0F, 1'b1, 8'hA6, 4'h0);
        rd_byte(7'h0F, 32'hA6);
        $display("test read write finished");
    endtask
    task automatic t_burst();
        cmd(7'h63, 1'b0, 8'h00, 4'h2);
        bus(1'b0, OFS_BURST_LO, 32'h0);
        chk(q & 32'hFFFF, 32'h5156);
        bus(1'b1, OFS_COMMAND, {12'h000, 4'h7, 8'h00, 1'b0, 7'h63});
        bus(1'b1, OFS_COMMAND, {12'h000, 4'h1, 8'h00, 1'b0, 7'h00});
        cmd(7'h00, 1'b0, 8'h00, 4'h1);
        bus(1'b0, OFS_BURST_LO, 32'h0);
        chk(q, 32'h53505156);
        bus(1'b0, OFS_BURST_HI, 32'h0);
        chk(q & 32'hFFFFFF, 32'h5C5D52);
        bus(1'b0, OFS_STATUS, 32'h0);
        chk(q & 32'h6, 32'h6);
        bus(1'b1, OFS_STATUS, 32'h16);
        bus(1'b0, OFS_STATUS, 32'h0);
        chk(q & 32'h16, 32'h0);
        cmd(7'h0D, 1'b1, 8'h21, 4'h0);
        cmd(7'h63, 1'b0, 8'h00, 4'h3);
        bus(1'b0, OFS_BURST_LO, 32'h0);
        chk(q & 32'hFFFFFF, 32'h595156);
        cmd(7'h0D, 1'b1, 8'h01, 4'h0);
        $display("test burst finished");
    endtask
    task automatic t_start_reset();
        rd_byte(7'h42, 32'h03);
        cmd(7'h42, 1'b1, 8'h05, 4'h0);
        cmd(7'h63, 1'b0, 8'h00, 4'h2);
        bus(1'b0, OFS_BURST_LO, 32'h0);
        chk(q & 32'hFFFF, 32'h5350);
        cmd(7'h0D, 1'b1, 8'h02, 4'h0);
        cmd(7'h3A, 1'b1, 8'h5A, 4'h0);
        rd_byte(7'h0D, 32'h01);
        rd_byte(7'h42, 32'h03);
        $display("test start and reset finished");
    endtask
    task automatic t_motion();
        motion_pin <= 1'b0;
        repeat (4) @(posedge hclk);
        bus(1'b0, OFS_STATUS, 32'h0);
        chk(q & 32'h18, 32'h10);
        motion_pin <= 1'b1;
        bus(1'b1, OFS_STATUS, 32'h10);
        bus(1'b0, OFS_STATUS, 32'h0);
        chk(q & 32'h18, 32'h08);
        bus(1'b1, OFS_CONFIG, 32'h1);
        bus(1'b0, OFS_CONFIG, 32'h0);
        chk(q, 32'h1);
        motion_pin <= 1'b0;
        bus(1'b1, OFS_STATUS, 32'h10);
        bus(1'b0, OFS_STATUS, 32'h0);
        chk(q & 32'h18, 32'h0);
        motion_pin <= 1'b1;
        repeat (8) @(posedge hclk);
        motion_pin <= 1'b0;
        repeat (4) @(posedge hclk);
        bus(1'b0, OFS_STATUS, 32'h0);
        chk(q & 32'h18, 32'h10);
        $display("test motion finished");
    endtask
    task automatic test_done();
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        repeat (80000) @(posedge hclk);
        err_total++;
        test_done();
    end
    initial begin
        repeat (4) @(posedge hclk);
        chk({30'h0, spi_out.sclk, spi_out.port_select_n}, 32'h3);
        chk({30'h0, hresp, hreadyout}, 32'h1);
        hresetn <= 1'b1;
        t_regs();
        t_rw();
        t_burst();
        t_start_reset();
        t_motion();
        test_done();
    end
endmodule // tb_motion_sensor_host
